//--- rtl/adcsc_top.sv
// converter control, sequencing and result registers
//------------------------------------------------------------
// What this block does
// - result left-justified: top eight bits high byte, low two in bits 7:6
// - inputs 0/4 to A, 1/5 to B, 2/6 to C, 3/7 to D
// - result registers clear on reset and on standby entry
// - high byte read directly, low byte through a byte latch
// - high-byte read loads latch; read high first, low-only may be stale
// - control/status register clears on reset and standby
// - end flag sets after single conversion or after whole scan pass
// - end flag cleared by reset, standby, or a zero write after a read seeing one
// - interrupt request only while interrupt enable is one
// - single mode: start bit begins one conversion, hardware clears it
// - scan mode repeats until start cleared by software, reset or standby
// - each scan pass and restart begins at group's first input
// - external trigger pin can also set the start bit
// - mode bit zero selects single, one selects scan
// - first conversion 266 or 134 states, doubled at half clock
// - later scan conversions 256 or 128 states, doubled at half clock
// - single mode: bit 2 picks group, bits 1:0 pick input
// - scan mode: bits 1:0 give count n, scan first n+1 inputs
// - trigger register resets to 0x7f, low seven bits read one
// - trigger enable set: falling pin edge sets start bit, else ignored
//------------------------------------------------------------
module adcsc_top (
	// clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	// power state and peripheral clock rate
	input wire logic I_STANDBY,
	input wire logic I_PCLK_HALF,
	// cpu byte bus
	input wire logic [15:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [7:0] O_RDATA,
	// analog front end
	input wire logic [9:0] I_CONV_DATA,
	output logic [2:0] O_CH_SEL,
	output logic O_SAMPLE,
	output logic O_CONV_BUSY,
	// external trigger and interrupt
	input wire logic I_EXT_TRIGGER_PIN_N,
	output logic O_CONVERSION_END_IRQ
);

	typedef enum logic {SEQ_IDLE, SEQ_CONV} adcsc_seq_e;

	adcsc_timer_if tif ();

	adcsc_seq_e state;
	logic conversion_end_flag;
	logic end_interrupt_enable;
	logic conversion_start_bit;
	logic scan_mode;
	logic conv_time_select;
	logic group_select;
	logic [1:0] channel_select;
	logic ext_trigger_enable;
	logic flag_seen;
	logic [9:0] result_reg [4];
	logic [7:0] low_latch;
	logic [1:0] scan_index;
	logic trg_s1;
	logic trg_s2;
	logic trg_s3;
	logic trig_fall;
	logic wr_csr;
	logic wr_trig;
	logic rd_csr;
	logic begin_conv;
	logic conv_done;
	logic pass_done;
	logic [1:0] slot;
	logic [adcsc_pkg::TIMER_W-1:0] first_len;
	logic [adcsc_pkg::TIMER_W-1:0] next_len;
	logic [7:0] csr_value;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic logic is_result(input logic [15:0] addr);
		return addr >= adcsc_pkg::ADDR_RESULT_A_HIGH && addr <= adcsc_pkg::ADDR_RESULT_D_LOW;
	endfunction

	function automatic logic [1:0] result_index(input logic [15:0] addr);
		return addr[2:1];
	endfunction

	assign wr_csr = I_WR && (I_ADDR == adcsc_pkg::ADDR_CONVERSION_CONTROL_STATUS);
	assign wr_trig = I_WR && (I_ADDR == adcsc_pkg::ADDR_TRIGGER_CONTROL);
	assign rd_csr = I_RD && (I_ADDR == adcsc_pkg::ADDR_CONVERSION_CONTROL_STATUS);

	assign csr_value = {conversion_end_flag, end_interrupt_enable, conversion_start_bit,
		scan_mode, conv_time_select, group_select, channel_select};

	// ----------------------------------------
	// trigger pin synchroniser
	// ----------------------------------------
	// pin idles high; first stage read only by the second
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			trg_s1 <= 1'b1;
			trg_s2 <= 1'b1;
			trg_s3 <= 1'b1;
		end else begin
			trg_s1 <= I_EXT_TRIGGER_PIN_N;
			trg_s2 <= trg_s1;
			trg_s3 <= trg_s2;
		end
	end

	assign trig_fall = trg_s3 && !trg_s2 && ext_trigger_enable;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// restart at first
	assign begin_conv = (state == SEQ_IDLE) && conversion_start_bit;
	assign conv_done = (state == SEQ_CONV) && conversion_start_bit && tif.done;
	assign pass_done = !scan_mode || (scan_index == channel_select);
	assign slot = scan_mode ? scan_index : channel_select;

	assign first_len = (conv_time_select ? adcsc_pkg::FIRST_FAST_STATES : adcsc_pkg::FIRST_SLOW_STATES)
		<< I_PCLK_HALF;
	assign next_len = (conv_time_select ? adcsc_pkg::NEXT_FAST_STATES : adcsc_pkg::NEXT_SLOW_STATES)
		<< I_PCLK_HALF;

	assign tif.kick = begin_conv || (conv_done && scan_mode);
	assign tif.length = begin_conv ? first_len : next_len;
	// start bit cleared mid-conversion drops the conversion
	assign tif.abort = (state == SEQ_CONV) && !conversion_start_bit;

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state <= SEQ_IDLE;
		end else if (I_STANDBY) begin
			state <= SEQ_IDLE;
		end else begin
			unique case (state)
				SEQ_IDLE: begin
					if (begin_conv) begin
						state <= SEQ_CONV;
					end
				end
				SEQ_CONV: begin
					if (!conversion_start_bit || (conv_done && !scan_mode)) begin
						state <= SEQ_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			scan_index <= 2'h0;
		end else if (begin_conv || I_STANDBY) begin
			scan_index <= 2'h0;
		end else if (conv_done) begin
			scan_index <= pass_done ? 2'h0 : scan_index + 2'h1;
		end
	end

	adcsc_conv_timer u_timer (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RST_N),
		.tif(tif)
	);

	// ----------------------------------------
	// control/status register
	// ----------------------------------------
	// cleared fields
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			{end_interrupt_enable, scan_mode, conv_time_select, group_select, channel_select} <= '0;
		end else if (I_STANDBY) begin
			{end_interrupt_enable, scan_mode, conv_time_select, group_select, channel_select} <= '0;
		end else if (wr_csr) begin
			end_interrupt_enable <= I_WDATA[adcsc_pkg::CSR_IRQ_EN_BIT];
			scan_mode <= I_WDATA[adcsc_pkg::CSR_MODE_BIT];
			conv_time_select <= I_WDATA[adcsc_pkg::CSR_CKS_BIT];
			group_select <= I_WDATA[adcsc_pkg::CSR_GROUP_BIT];
			channel_select <= I_WDATA[1:0];
		end
	end

	// start self-clear
	// trigger set placed last so a pin edge wins over a write or the self-clear; standby still drops it
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			conversion_start_bit <= 1'b0;
		end else if (I_STANDBY) begin
			conversion_start_bit <= 1'b0;
		end else begin
			if (conv_done && !scan_mode) begin
				conversion_start_bit <= 1'b0;
			end
			if (wr_csr) begin
				conversion_start_bit <= I_WDATA[adcsc_pkg::CSR_START_BIT];
			end
			if (trig_fall) begin
				conversion_start_bit <= 1'b1;
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			flag_seen <= 1'b0;
		end else if (I_STANDBY || wr_csr) begin
			flag_seen <= 1'b0;
		end else if (rd_csr && conversion_end_flag) begin
			flag_seen <= 1'b1;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			conversion_end_flag <= 1'b0;
		end else if (I_STANDBY) begin
			conversion_end_flag <= 1'b0;
		end else if (conv_done && pass_done) begin
			conversion_end_flag <= 1'b1;
		end else if (wr_csr && flag_seen && !I_WDATA[adcsc_pkg::CSR_FLAG_BIT]) begin
			conversion_end_flag <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ext_trigger_enable <= 1'b0;
		end else if (I_STANDBY) begin
			ext_trigger_enable <= 1'b0;
		end else if (wr_trig) begin
			ext_trigger_enable <= I_WDATA[adcsc_pkg::TRIG_EN_BIT];
		end
	end

	// ----------------------------------------
	// result registers
	// ----------------------------------------
	for (genvar g = 0; g < 4; g++) begin : g_result
		always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
			if (!I_RST_N) begin
				result_reg[g] <= adcsc_pkg::RESULT_RESET;
			end else if (I_STANDBY) begin
				result_reg[g] <= adcsc_pkg::RESULT_RESET;
			end else if (conv_done && slot == 2'(g)) begin
				result_reg[g] <= I_CONV_DATA;
			end
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	// latched low byte
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			low_latch <= 8'h00;
		end else if (I_STANDBY) begin
			low_latch <= 8'h00;
		end else if (I_RD && is_result(I_ADDR) && !I_ADDR[0]) begin
			low_latch <= {result_reg[result_index(I_ADDR)][1:0], adcsc_pkg::RESULT_PAD};
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_RDATA <= 8'h00;
		end else if (I_RD) begin
			if (is_result(I_ADDR)) begin
				O_RDATA <= I_ADDR[0] ? low_latch : result_reg[result_index(I_ADDR)][9:2];
			end else if (I_ADDR == adcsc_pkg::ADDR_CONVERSION_CONTROL_STATUS) begin
				O_RDATA <= csr_value;
			end else if (I_ADDR == adcsc_pkg::ADDR_TRIGGER_CONTROL) begin
				O_RDATA <= {ext_trigger_enable, adcsc_pkg::TRIG_FIXED_ONES};
			end else begin
				O_RDATA <= adcsc_pkg::UNMAPPED_READ;
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// gated by enable
	assign O_CONVERSION_END_IRQ = conversion_end_flag && end_interrupt_enable;
	// a scan kick shows the channel it starts, not the one ending
	assign O_CH_SEL = {group_select, !(tif.kick && scan_mode) ? slot :
		(begin_conv || pass_done) ? 2'h0 : scan_index + 2'h1};
	assign O_SAMPLE = tif.kick;
	assign O_CONV_BUSY = (state == SEQ_CONV);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_RST_N);

	AST_LOW_BITS_ZERO: assert property (
		I_RD && I_ADDR == adcsc_pkg::ADDR_RESULT_A_LOW |=> O_RDATA[5:0] == 6'h00)
		else $error("low result byte has nonzero pad bits");

	AST_SLOT_A: assert property (
		conv_done && slot == 2'h0 && !I_STANDBY |=> result_reg[0] == $past(I_CONV_DATA))
		else $error("result not stored in register a");

	AST_STANDBY_CLEAR: assert property (
		I_STANDBY |=> result_reg[3] == 10'h000 && csr_value == 8'h00 && !ext_trigger_enable)
		else $error("standby did not clear registers");

	AST_LATCH_PAIR: assert property (
		I_RD && I_ADDR == adcsc_pkg::ADDR_RESULT_B_HIGH && !I_STANDBY ##1
		I_RD && I_ADDR == adcsc_pkg::ADDR_RESULT_B_LOW |=> O_RDATA[7:6] == $past(result_reg[1][1:0], 2))
		else $error("low byte not taken from latch");

	AST_FLAG_NEEDS_READ: assert property (
		conversion_end_flag && !flag_seen && !I_STANDBY |=> conversion_end_flag)
		else $error("flag cleared without prior read");

	AST_FLAG_ON_PASS: assert property (
		conv_done && pass_done && !I_STANDBY |=> conversion_end_flag)
		else $error("flag not set at end of conversion");

	AST_IRQ_ENABLE: assert property (
		!end_interrupt_enable |-> !O_CONVERSION_END_IRQ)
		else $error("interrupt without enable");

	AST_SINGLE_STOPS: assert property (
		conv_done && !scan_mode && !I_WR && !trig_fall && !I_STANDBY |=>
		!conversion_start_bit && state == SEQ_IDLE)
		else $error("single conversion did not clear start");

	AST_SCAN_GOES_ON: assert property (
		conv_done && scan_mode && !I_WR && !I_STANDBY |=> conversion_start_bit && state == SEQ_CONV)
		else $error("scan stopped by itself");

	AST_TRIGGER_START: assert property (
		trig_fall && !I_STANDBY |=> conversion_start_bit)
		else $error("trigger edge did not set start");

	AST_FIRST_LENGTH: assert property (
		begin_conv && !conv_time_select && !I_PCLK_HALF |-> tif.length == 10'd266)
		else $error("first conversion length wrong");

endmodule

//--- rtl/adcsc_pkg.sv
// constants shared by the converter control block and its conversion timer
package adcsc_pkg;

	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [15:0] ADDR_RESULT_A_HIGH = 16'hffe0;
	localparam logic [15:0] ADDR_RESULT_A_LOW = 16'hffe1;
	localparam logic [15:0] ADDR_RESULT_B_HIGH = 16'hffe2;
	localparam logic [15:0] ADDR_RESULT_B_LOW = 16'hffe3;
	localparam logic [15:0] ADDR_RESULT_C_HIGH = 16'hffe4;
	localparam logic [15:0] ADDR_RESULT_C_LOW = 16'hffe5;
	localparam logic [15:0] ADDR_RESULT_D_HIGH = 16'hffe6;
	localparam logic [15:0] ADDR_RESULT_D_LOW = 16'hffe7;
	localparam logic [15:0] ADDR_CONVERSION_CONTROL_STATUS = 16'hffe8;
	localparam logic [15:0] ADDR_TRIGGER_CONTROL = 16'hffe9;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CSR_FLAG_BIT = 7;
	localparam int CSR_IRQ_EN_BIT = 6;
	localparam int CSR_START_BIT = 5;
	localparam int CSR_MODE_BIT = 4;
	localparam int CSR_CKS_BIT = 3;
	localparam int CSR_GROUP_BIT = 2;
	localparam int TRIG_EN_BIT = 7;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] CSR_RESET = 8'h00;
	localparam logic [6:0] TRIG_FIXED_ONES = 7'h7f;
	localparam logic [9:0] RESULT_RESET = 10'h000;
	localparam logic [5:0] RESULT_PAD = 6'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ----------------------------------------
	// conversion lengths in states (one state = one system clock)
	// ----------------------------------------
	localparam int TIMER_W = 10;
	localparam logic [TIMER_W-1:0] FIRST_SLOW_STATES = 10'd266;
	localparam logic [TIMER_W-1:0] FIRST_FAST_STATES = 10'd134;
	localparam logic [TIMER_W-1:0] NEXT_SLOW_STATES = 10'd256;
	localparam logic [TIMER_W-1:0] NEXT_FAST_STATES = 10'd128;

endpackage

//--- rtl/adcsc_timer_if.sv
// handshake between the sequencer and the conversion timer
interface adcsc_timer_if;
	logic kick;
	logic abort;
	logic [adcsc_pkg::TIMER_W-1:0] length;
	logic done;
	logic busy;

	modport ctrl (
		output kick,
		output abort,
		output length,
		input done,
		input busy
	);

	modport timer (
		input kick,
		input abort,
		input length,
		output done,
		output busy
	);
endinterface

//--- rtl/adcsc_conv_timer.sv
// counts out one conversion and pulses done in its last state
module adcsc_conv_timer (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// sequencer side
	adcsc_timer_if.timer tif
);

	logic [adcsc_pkg::TIMER_W-1:0] count;

	// ----------------------------------------
	// down counter
	// ----------------------------------------
	// a kick in the done cycle reloads, so scan passes run back to back
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count <= '0;
		end else if (tif.kick) begin
			count <= tif.length;
		end else if (tif.abort) begin
			count <= '0;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	assign tif.done = (count == adcsc_pkg::TIMER_W'(1));
	assign tif.busy = (count != '0);

	AST_TIMER_STEP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(count != '0) && !tif.kick && !tif.abort |=> count == $past(count) - 1'b1)
		else $error("timer did not count down by one");

endmodule

//--- tb/adcsc_cpu_model.sv
// cpu byte-bus master standing in front of the converter control block
module adcsc_cpu_model (
	// clock
	input wire logic i_clk,
	// byte bus toward the block
	output logic [15:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		o_addr = 16'h0000;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	// strobes change at the falling edge, held for one rising edge
	task automatic write(input logic [15:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(negedge i_clk);
		o_wr = 1'b0;
	endtask

	task automatic read(input logic [15:0] a);
		@(negedge i_clk);
		o_addr = a;
		o_rd = 1'b1;
		@(negedge i_clk);
		o_rd = 1'b0;
	endtask

	// high byte first
	// low byte only comes right through the latch after its high byte
	task automatic read_pair(input logic [15:0] a_high);
		read(a_high);
		read(a_high + 16'h0001);
	endtask
endmodule

//--- tb/adcsc_top_test.sv
// self-checking bench for the converter control block
module adcsc_top_test;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam logic [15:0] res_a = adcsc_pkg::ADDR_RESULT_A_HIGH;
	localparam logic [15:0] csr_a = adcsc_pkg::ADDR_CONVERSION_CONTROL_STATUS;
	localparam logic [15:0] trg_a = adcsc_pkg::ADDR_TRIGGER_CONTROL;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic standby = 1'b0;
	logic pclk_half = 1'b0;
	logic trig_n = 1'b1;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic [9:0] conv_data;
	logic [2:0] ch_sel;
	logic sample;
	logic busy;
	logic irq;
	logic [9:0] conv_val [8];
	logic [2:0] cur_ch = 3'h0;
	logic rd_q = 1'b0;
	logic [7:0] exp_q [$];
	int fails = 0;
	int n_tests = 0;
	int seed = 48339;

	always #50 clk = ~clk;

	adcsc_top uut (
		.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_STANDBY(standby), .I_PCLK_HALF(pclk_half),
		.I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
		.I_CONV_DATA(conv_data), .O_CH_SEL(ch_sel), .O_SAMPLE(sample), .O_CONV_BUSY(busy),
		.I_EXT_TRIGGER_PIN_N(trig_n), .O_CONVERSION_END_IRQ(irq)
	);

	adcsc_cpu_model cpu (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

	// front end holds the input picked at the sample pulse
	always @(posedge clk) if (sample === 1'b1) cur_ch <= ch_sel;
	assign conv_data = conv_val[cur_ch];

	// ----------------------------------------
	// checking
	// ----------------------------------------
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic timeout();
		fails++;
		$display("ERROR at %0t: wait ran out", $time);
		end_of_test();
	endtask

	// read data is valid the cycle after the strobe
	always @(posedge clk) rd_q <= rd;
	always @(negedge clk) begin
		if (rd_q === 1'b1) begin
			if (exp_q.size() == 0) timeout();
			else check(rdata, exp_q.pop_front());
		end
	end

	task automatic rd_exp(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		cpu.read(a);
	endtask

	task automatic chk_result(input logic [1:0] s, input logic [9:0] v);
		exp_q.push_back(v[9:2]);
		exp_q.push_back({v[1:0], 6'h00});
		cpu.read_pair(res_a + {13'h0000, s, 1'b0});
	endtask

	task automatic wait_sample(input int lim);
		for (int i = 0; i < lim && sample !== 1'b1; i++) @(negedge clk);
		if (sample !== 1'b1) timeout();
	endtask

	task automatic count_until(input bit on_irq, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((on_irq ? irq : sample) !== 1'b1 && n < 1200);
		if (n >= 1200) timeout();
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		int n;
		int l1;
		int l2;
		logic [7:0] cfg;
		logic [1:0] nn;
		for (int i = 0; i < 8; i++) conv_val[i] = 10'($random(seed));
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		rd_exp(csr_a, 8'h00);
		rd_exp(trg_a, 8'h7f);
		rd_exp(16'hffea, adcsc_pkg::UNMAPPED_READ);
		cpu.write(res_a, 8'h55);
		for (int s = 0; s < 4; s++) chk_result(2'(s), 10'h000);
		$display("test reset values done");

		for (int c = 0; c < 8; c++) begin
			pclk_half = 1'($random(seed));
			cfg = {4'h6, c[1], c[2:0]};
			l1 = (c[1] ? 134 : 266) * (pclk_half ? 2 : 1);
			cpu.write(csr_a, cfg);
			wait_sample(4);
			check(ch_sel, cfg[2:0]);
			count_until(1'b1, n);
			check(n, l1 + 1);
			rd_exp(csr_a, cfg ^ 8'ha0);
			chk_result(c[1:0], conv_val[c]);
			cpu.write(csr_a, 8'h80);
			check(irq, 1'b0);
			// write after write is not armed
			cpu.write(csr_a, 8'h00);
			rd_exp(csr_a, 8'h80);
			cpu.write(csr_a, 8'h00);
			cpu.write(csr_a, 8'h80);
			rd_exp(csr_a, 8'h00);
		end
		$display("test single mode done");

		for (int r = 0; r < 2; r++) begin
			for (int i = 0; i < 8; i++) conv_val[i] = 10'($random(seed));
			pclk_half = 1'($random(seed));
			nn = 2'($random(seed));
			cfg = {4'h7, 1'($random(seed)), r[0], nn};
			l1 = (cfg[3] ? 134 : 266) * (pclk_half ? 2 : 1);
			l2 = (cfg[3] ? 128 : 256) * (pclk_half ? 2 : 1);
			cpu.write(csr_a, cfg);
			wait_sample(4);
			for (int j = 0; j <= nn; j++) begin
				check(ch_sel, {r[0], 2'(j)});
				check(irq, 1'b0);
				count_until(1'b0, n);
				check(n, j == 0 ? l1 : l2);
			end
			check(ch_sel, {r[0], 2'b00});
			@(negedge clk);
			check(irq, 1'b1);
			cpu.write(csr_a, cfg & 8'hdf);
			rd_exp(csr_a, cfg ^ 8'ha0);
			for (int j = 0; j <= nn; j++) chk_result(2'(j), conv_val[{r[0], 2'(j)}]);
			rd_exp(csr_a, cfg ^ 8'ha0);
			cpu.write(csr_a, cfg);
			wait_sample(4);
			check(ch_sel, {r[0], 2'b00});
			cpu.write(csr_a, cfg & 8'h5f);
		end
		$display("test scan mode done");

		pclk_half = 1'b0;
		cpu.write(trg_a, 8'h80);
		rd_exp(trg_a, 8'hff);
		cpu.write(csr_a, 8'h46);
		trig_n = 1'b0;
		wait_sample(8);
		check(ch_sel, 3'h6);
		count_until(1'b1, n);
		check(n, 267);
		rd_exp(csr_a, 8'hc6);
		trig_n = 1'b1;
		cpu.write(csr_a, 8'h46);
		cpu.write(trg_a, 8'h00);
		rd_exp(trg_a, 8'h7f);
		trig_n = 1'b0;
		repeat (10) @(negedge clk);
		rd_exp(csr_a, 8'h46);
		trig_n = 1'b1;
		$display("test trigger done");

		cpu.write(trg_a, 8'h80);
		cpu.write(csr_a, 8'h73);
		wait_sample(4);
		repeat (300) @(negedge clk);
		check(busy, 1'b1);
		standby = 1'b1;
		repeat (2) @(negedge clk);
		standby = 1'b0;
		@(negedge clk);
		check(busy, 1'b0);
		rd_exp(csr_a, 8'h00);
		rd_exp(trg_a, 8'h7f);
		for (int s = 0; s < 4; s++) chk_result(2'(s), 10'h000);
		$display("test standby done");
		end_of_test();
	end
endmodule
